// ==== logic/sdpwm_pkg.sv ====
`default_nettype none
package sdpwm_pkg;

  // ----------------------------------------------------------------
  // Clocking and sizes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned CLK_NS    = 100;
  localparam int unsigned NCH       = 4;
  localparam int unsigned PER_W     = 8;
  localparam int unsigned OVC_CW    = 8;
  localparam int unsigned GAP_W     = 3;
  localparam int unsigned RST_W     = 16;
  localparam int unsigned RFC_W     = 3;

  typedef logic [PER_W-1:0] sdpwm_per_t;

  // ----------------------------------------------------------------
  // Switching frequency
  // ----------------------------------------------------------------
  localparam int unsigned F_LOW_HZ    = 600_000;
  localparam int unsigned F_HIGH_HZ   = 1_000_000;
  localparam int unsigned SYNC_MIN_HZ = 250_000;
  localparam int unsigned SYNC_MAX_HZ = 2_250_000;
  localparam sdpwm_per_t  PER_LOW      = sdpwm_per_t'((CLK_HZ + F_LOW_HZ / 2) / F_LOW_HZ);
  localparam sdpwm_per_t  PER_HIGH     = sdpwm_per_t'((CLK_HZ + F_HIGH_HZ / 2) / F_HIGH_HZ);
  localparam sdpwm_per_t  SYNC_TIMEOUT = sdpwm_per_t'((2 * CLK_HZ) / SYNC_MIN_HZ);
  localparam sdpwm_per_t  SYNC_MIN_PER = sdpwm_per_t'(CLK_HZ / SYNC_MAX_HZ);
  localparam int unsigned OFF_DIV      = 12;
  localparam int unsigned CHAIN_DIV    = 8;
  localparam int unsigned HALF_DIV     = 2;
  localparam int unsigned QUARTERS     = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned MIN_ON_NS   = 20;
  localparam int unsigned REFRESH_NS  = 40;
  localparam sdpwm_per_t  MIN_ON_CYC  = sdpwm_per_t'(((MIN_ON_NS + CLK_NS - 1) / CLK_NS) > 0 ?
                                                     ((MIN_ON_NS + CLK_NS - 1) / CLK_NS) : 1);
  localparam sdpwm_per_t  REFRESH_CYC = sdpwm_per_t'((REFRESH_NS / CLK_NS) > 0 ?
                                                     (REFRESH_NS / CLK_NS) : 1);

  // ----------------------------------------------------------------
  // Fault counting
  // ----------------------------------------------------------------
  localparam logic [OVC_CW-1:0] OVC_TRIP    = OVC_CW'(127);
  localparam logic [GAP_W-1:0]  OVC_GAP     = GAP_W'(6);
  localparam int unsigned       RESTART_DEF = 32768;
  localparam logic [RFC_W-1:0]  REFRESH_SLOT = '0;

  typedef enum logic [2:0] {
    DRV_OFF,
    DRV_HIGH,
    DRV_LOW,
    DRV_FLOAT,
    DRV_REFRESH
  } sdpwm_drv_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic sdpwm_per_t sdpwm_min_off(input sdpwm_per_t per);
    sdpwm_min_off = sdpwm_per_t'((32'(per) + OFF_DIV - 1) / OFF_DIV);
  endfunction

  function automatic sdpwm_per_t sdpwm_phase(input sdpwm_per_t per, input int unsigned idx);
    int unsigned k;
    case (idx)
      1: k = 2;
      2: k = 1;
      3: k = 3;
      default: k = 0;
    endcase
    sdpwm_phase = sdpwm_per_t'((32'(per) * k) / QUARTERS);
  endfunction

  function automatic sdpwm_per_t sdpwm_rel(input sdpwm_per_t cnt, input sdpwm_per_t off,
                                           input sdpwm_per_t per);
    sdpwm_rel = (cnt >= off) ? sdpwm_per_t'(cnt - off) : sdpwm_per_t'(cnt + per - off);
  endfunction

endpackage
`default_nettype wire

// ==== logic/sdpwm_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdpwm_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sdpwm_sync2
`default_nettype wire

// ==== logic/sdpwm_fault.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdpwm_fault #(
  parameter int unsigned RESTART_CYCLES = sdpwm_pkg::RESTART_DEF
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tick,
  input  wire logic allowed,
  input  wire logic ovc_cycle,
  output logic      hold
);
  import sdpwm_pkg::*;

  localparam logic [RST_W-1:0] RESTART_LAST = RST_W'(RESTART_CYCLES - 1);

  logic [OVC_CW-1:0] cnt_q;
  logic [GAP_W-1:0]  gap_q;
  logic [RST_W-1:0]  wait_q;

  // ----------------------------------------------------------------
  // Fault cycle count (gaps under seven clean cycles kept) and restart wait
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      gap_q  <= '0;
      wait_q <= '0;
      hold   <= 1'b0;
    end else if (!allowed) begin
      cnt_q  <= '0;
      gap_q  <= '0;
      wait_q <= '0;
      hold   <= 1'b0;
    end else if (tick) begin
      if (hold) begin
        wait_q <= wait_q + 1'b1;
        if (wait_q == RESTART_LAST) begin // [R2]
          hold   <= 1'b0;
          wait_q <= '0;
        end
      end else if (ovc_cycle) begin
        gap_q <= '0;
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == OVC_TRIP) begin // [R1]
          hold  <= 1'b1;
          cnt_q <= '0;
        end
      end else if (cnt_q != '0) begin
        gap_q <= gap_q + 1'b1;
        if (gap_q == OVC_GAP) begin // [R3]
          cnt_q <= '0;
          gap_q <= '0;
        end
      end
    end
  end
endmodule // sdpwm_fault
`default_nettype wire

// ==== logic/sdpwm_top.sv ====
// How it works
// R1: 128 overcurrent cycles, with no run of seven clean cycles between them, float the drive and reset soft-start.
// R2: After that shutdown wait 32768 switching cycles, then try to start again.
// R3: Fault count survives gaps; seven clean cycles in a row clear it.
// R4: Negative overcurrent blocks driving low except for the refresh pulse.
// R5: Under negative overcurrent, pulse low for one 100ns clock once every eight cycles.
// R6: Cycle start sets the drive high when error-above-floor is flagged.
// R7: Ramp-crossing flag ends the high phase.
// R8: Error below floor at cycle start keeps the drive low all cycle.
// R9: High lasts at least 20ns; off-time at least one twelfth of period.
// R10: External sync clock locks the oscillator; channel 1 rises on its edge.
// R11: Sync held low: frequency select picks between two presets.
// R12: Sync high or floating: use the resistor-programmed period.
// R13: All enables low: chain clock output held high.
// R14: All enables low: reference and oscillator stop, everything idle.
// R15: Disabled channel holds its duty command at zero.
// R16: Shared duty mode holds the command until every enable is high.
// R17: Supply lockout disables all channels.
// R18: Any enable starts the reference; channels run once lockout clears.
// R19: Each drive is one three-state wire: high, low or floating.
// R20: Select low gives 600kHz, select high gives 1MHz.
// R21: Counters step once per switching cycle; flags sampled within the cycle.
`timescale 1ns/1ps
`default_nettype none
module sdpwm_top #(
  parameter int unsigned RESTART_CYCLES = sdpwm_pkg::RESTART_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        sync_clock_in,
  input  wire logic                        frequency_select,
  input  wire sdpwm_pkg::sdpwm_per_t       rate_period_setting,
  input  wire logic [sdpwm_pkg::NCH-1:0]   channel_enable,
  input  wire logic                        shared_duty,
  input  wire logic                        supply_lockout,
  input  wire logic [sdpwm_pkg::NCH-1:0]   error_above_floor,
  input  wire logic [sdpwm_pkg::NCH-1:0]   ramp_crossed,
  input  wire logic [sdpwm_pkg::NCH-1:0]   overcurrent_fault,
  input  wire logic [sdpwm_pkg::NCH-1:0]   negative_overcurrent,
  output logic      [sdpwm_pkg::NCH-1:0]   channel_drive,
  output logic      [sdpwm_pkg::NCH-1:0]   channel_drive_oe_n,
  output logic      [sdpwm_pkg::NCH-1:0]   soft_start_reset,
  output logic      [sdpwm_pkg::NCH-1:0]   duty_hold,
  output logic                             reference_on,
  output logic                             oscillator_on,
  output logic                             sync_locked,
  output logic                             chain_clock_out
);
  import sdpwm_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NCH+1:0] pins_s;
  logic           sync_s;
  logic           fsel_s;
  logic [NCH-1:0] en_s;

  sdpwm_sync2 #(
    .W (NCH + 2)
  ) u_pins (
    .clk  (clk),
    .rstn (rstn),
    .d    ({channel_enable, frequency_select, sync_clock_in}),
    .q    (pins_s)
  );

  assign sync_s = pins_s[0];
  assign fsel_s = pins_s[1];
  assign en_s   = pins_s[NCH+1:2];

  logic any_en;
  logic all_en;

  assign any_en = |en_s;
  assign all_en = &en_s;

  // ----------------------------------------------------------------
  // Reference and oscillator power
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reference_on  <= 1'b0;
      oscillator_on <= 1'b0;
    end else begin
      reference_on  <= any_en; // [R14] [R18]
      oscillator_on <= any_en & reference_on; // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Sync edge detection and period measurement
  // ----------------------------------------------------------------
  logic       sync_d_q;
  logic       sync_rise;
  sdpwm_per_t since_q;
  sdpwm_per_t meas_q;

  assign sync_rise = sync_s & ~sync_d_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_d_q <= 1'b0;
    end else begin
      sync_d_q <= sync_s;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_q <= SYNC_TIMEOUT;
    end else if (sync_rise) begin
      since_q <= '0;
    end else if (since_q != SYNC_TIMEOUT) begin
      since_q <= since_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meas_q      <= PER_HIGH;
      sync_locked <= 1'b0;
    end else if (!oscillator_on) begin
      sync_locked <= 1'b0;
    end else if (sync_rise) begin
      if (since_q < SYNC_TIMEOUT && since_q >= SYNC_MIN_PER) begin // [R10]
        meas_q      <= since_q + 1'b1;
        sync_locked <= 1'b1;
      end
    end else if (since_q == SYNC_TIMEOUT) begin
      sync_locked <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Period choice
  // ----------------------------------------------------------------
  sdpwm_per_t per;

  always_comb begin
    if (sync_locked) begin
      per = meas_q; // [R10]
    end else if (sync_s) begin
      per = rate_period_setting; // [R12]
    end else if (fsel_s) begin
      per = PER_HIGH; // [R11] [R20]
    end else begin
      per = PER_LOW; // [R11] [R20]
    end
  end

  // ----------------------------------------------------------------
  // Switching cycle counter
  // ----------------------------------------------------------------
  sdpwm_per_t cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (!oscillator_on) begin
      cnt_q <= '0; // [R14]
    end else if (sync_locked && sync_rise) begin
      cnt_q <= '0; // [R10]
    end else if (cnt_q >= per - 1'b1) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Chain clock
  // ----------------------------------------------------------------
  sdpwm_per_t chain_pos;

  assign chain_pos = sdpwm_rel(cnt_q, sdpwm_per_t'(per / CHAIN_DIV), per);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chain_clock_out <= 1'b1;
    end else if (!any_en || !oscillator_on) begin
      chain_clock_out <= 1'b1; // [R13]
    end else begin
      chain_clock_out <= chain_pos < sdpwm_per_t'(per / HALF_DIV);
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  sdpwm_per_t off_at;

  assign off_at = sdpwm_per_t'(per - sdpwm_min_off(per));

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic             tick;
    logic             ch_ok;
    logic             hold;
    logic             active;
    logic             ovc_seen_q;
    logic [RFC_W-1:0] rcyc_q;
    sdpwm_per_t       rel;
    sdpwm_per_t       tcnt_q;
    sdpwm_drv_t       st_q;
    sdpwm_drv_t       st_d;
    logic             end_high;

    assign rel   = sdpwm_rel(cnt_q, sdpwm_phase(per, i), per);
    assign tick  = oscillator_on && (rel == '0); // [R21]
    assign ch_ok = en_s[i] & reference_on & ~supply_lockout; // [R17] [R18]

    // Overcurrent seen anywhere in the cycle; a new flag wins over the restart
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ovc_seen_q <= 1'b0;
      end else if (tick) begin
        ovc_seen_q <= overcurrent_fault[i]; // [R21]
      end else if (overcurrent_fault[i]) begin
        ovc_seen_q <= 1'b1;
      end
    end

    sdpwm_fault #(
      .RESTART_CYCLES (RESTART_CYCLES)
    ) u_fault (
      .clk       (clk),
      .rstn      (rstn),
      .tick      (tick),
      .allowed   (ch_ok),
      .ovc_cycle (ovc_seen_q | overcurrent_fault[i]),
      .hold      (hold)
    );

    assign active = ch_ok & ~hold;

    // Refresh slot counter, once per switching cycle
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rcyc_q <= '0;
      end else if (!active) begin
        rcyc_q <= '0;
      end else if (tick) begin
        rcyc_q <= rcyc_q + 1'b1; // [R5] [R21]
      end
    end

    assign end_high = (ramp_crossed[i] && (tcnt_q + 1'b1 >= MIN_ON_CYC)) // [R7] [R9]
                      || (rel == off_at); // [R9]

    // Drive state
    always_comb begin
      st_d = st_q;
      if (!active) begin
        st_d = DRV_OFF; // [R1] [R17]
      end else if (tick) begin
        if (error_above_floor[i]) begin
          st_d = DRV_HIGH; // [R6]
        end else if (negative_overcurrent[i] && (rcyc_q == REFRESH_SLOT)) begin
          st_d = DRV_REFRESH; // [R5]
        end else if (negative_overcurrent[i]) begin
          st_d = DRV_FLOAT; // [R4]
        end else begin
          st_d = DRV_LOW; // [R8]
        end
      end else begin
        case (st_q)
          DRV_HIGH: begin
            if (end_high) begin
              if (!negative_overcurrent[i]) begin
                st_d = DRV_LOW;
              end else if (rcyc_q == REFRESH_SLOT) begin
                st_d = DRV_REFRESH; // [R5]
              end else begin
                st_d = DRV_FLOAT; // [R4]
              end
            end
          end
          DRV_LOW: begin
            if (negative_overcurrent[i]) begin
              st_d = DRV_FLOAT; // [R4]
            end
          end
          DRV_REFRESH: begin
            if (tcnt_q + 1'b1 >= REFRESH_CYC) begin
              st_d = DRV_FLOAT; // [R5]
            end
          end
          DRV_FLOAT: begin
            if (!negative_overcurrent[i]) begin
              st_d = DRV_LOW;
            end
          end
          DRV_OFF: begin
            st_d = DRV_OFF;
          end
          default: begin
            st_d = DRV_OFF;
          end
        endcase
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        st_q   <= DRV_OFF;
        tcnt_q <= '0;
      end else begin
        st_q   <= st_d;
        tcnt_q <= (st_d != st_q) ? '0 : tcnt_q + 1'b1;
      end
    end

    // Three-state drive pin
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        channel_drive[i]      <= 1'b0;
        channel_drive_oe_n[i] <= 1'b1;
      end else begin
        case (st_d)
          DRV_HIGH: begin
            channel_drive[i]      <= 1'b1; // [R19]
            channel_drive_oe_n[i] <= 1'b0;
          end
          DRV_LOW, DRV_REFRESH: begin
            channel_drive[i]      <= 1'b0; // [R19]
            channel_drive_oe_n[i] <= 1'b0;
          end
          default: begin
            channel_drive[i]      <= 1'b0; // [R19]
            channel_drive_oe_n[i] <= 1'b1;
          end
        endcase
      end
    end

    // Duty command hold and soft-start reset
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        duty_hold[i]        <= 1'b1;
        soft_start_reset[i] <= 1'b1;
      end else begin
        duty_hold[i]        <= ~en_s[i] | (shared_duty & ~all_en) | supply_lockout; // [R15] [R16]
        soft_start_reset[i] <= ~active; // [R1]
      end
    end
  end

endmodule // sdpwm_top
`default_nettype wire

// ==== tb/sdpwm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdpwm_monitor #(
  parameter int unsigned RESTART_CYCLES = sdpwm_pkg::RESTART_DEF
) (
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire logic [sdpwm_pkg::NCH-1:0] channel_enable,
  input wire logic                      shared_duty,
  input wire logic                      supply_lockout,
  input wire logic [sdpwm_pkg::NCH-1:0] ramp_crossed,
  input wire logic [sdpwm_pkg::NCH-1:0] negative_overcurrent,
  input wire logic [sdpwm_pkg::NCH-1:0] channel_drive,
  input wire logic [sdpwm_pkg::NCH-1:0] channel_drive_oe_n,
  input wire logic [sdpwm_pkg::NCH-1:0] duty_hold,
  input wire logic                      reference_on,
  input wire logic                      oscillator_on,
  input wire logic                      chain_clock_out
);
  import sdpwm_pkg::*;
  logic hi0;
  logic lo0;
  assign hi0 = !channel_drive_oe_n[0] && channel_drive[0];
  assign lo0 = !channel_drive_oe_n[0] && !channel_drive[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_chain_idle; !oscillator_on && !$past(oscillator_on) |-> chain_clock_out; endproperty
  a_chain_idle: assert property (p_chain_idle)
    else $error("chain clock not held high");
  property p_all_off; (channel_enable == 4'h0) [*4] |=> !reference_on && !oscillator_on; endproperty
  a_all_off: assert property (p_all_off)
    else $error("reference or oscillator still running");
  property p_ref_on; (channel_enable != 4'h0) [*4] |=> reference_on; endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference not started");
  property p_dis_hold; !channel_enable[0] [*3] |=> duty_hold[0]; endproperty
  a_dis_hold: assert property (p_dis_hold)
    else $error("duty command not forced on disabled channel");
  property p_shared; (shared_duty && channel_enable != 4'hF) [*3] |=> (duty_hold == 4'hF); endproperty
  a_shared: assert property (p_shared)
    else $error("shared duty command released early");
  property p_lockout; supply_lockout [*3] |=> (channel_drive_oe_n == 4'hF) && (duty_hold == 4'hF); endproperty
  a_lockout: assert property (p_lockout)
    else $error("channel active under lockout");
  property p_noc; negative_overcurrent[0] [*4] ##0 lo0 |=> !lo0; endproperty
  a_noc: assert property (p_noc)
    else $error("low side held on under negative overcurrent");
  property p_ramp; hi0 && $past(hi0) && ramp_crossed[0] |-> ##[1:2] !hi0; endproperty
  a_ramp: assert property (p_ramp)
    else $error("high phase not ended by ramp crossing");
endmodule // sdpwm_monitor
`default_nettype wire

// ==== tb/sdpwm_gate_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdpwm_gate_model (
  input  wire logic [sdpwm_pkg::NCH-1:0] drive,
  input  wire logic [sdpwm_pkg::NCH-1:0] drive_oe_n,
  output logic      [sdpwm_pkg::NCH-1:0] hi_on,
  output logic      [sdpwm_pkg::NCH-1:0] lo_on,
  output logic      [sdpwm_pkg::NCH-1:0] floating
);
  import sdpwm_pkg::*;
  // Floating pin parks both switches off
  assign floating = drive_oe_n;
  assign hi_on    = ~drive_oe_n & drive;
  assign lo_on    = ~drive_oe_n & ~drive;
endmodule // sdpwm_gate_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sdpwm_pkg::*;
  localparam int unsigned RST_N = 8;
  localparam int unsigned LIMIT = 12000;
  logic           clk = 1'b0, rstn = 1'b0, sync_clock_in = 1'b0, frequency_select = 1'b0, shared_duty = 1'b0;
  logic           supply_lockout = 1'b0, sync_run = 1'b0, sync_lvl = 1'b0;
  logic           reference_on, oscillator_on, sync_locked, chain_clock_out;
  sdpwm_per_t     rate_period_setting = 8'h0E;
  logic [NCH-1:0] channel_enable = 4'h0, error_above_floor = 4'hF, ramp_crossed = 4'h0;
  logic [NCH-1:0] overcurrent_fault = 4'h0, negative_overcurrent = 4'h0;
  logic [NCH-1:0] channel_drive, channel_drive_oe_n, soft_start_reset, duty_hold, hi_on, lo_on, floating;
  int             err_count = 0, checks = 0, cyc = 0, sc = 0, p, h, l, f, r;

  sdpwm_top #(.RESTART_CYCLES(RST_N)) sdpwm_top_inst (.*);
  sdpwm_gate_model sdpwm_gate_model_inst (.drive(channel_drive), .drive_oe_n(channel_drive_oe_n),
                                          .hi_on(hi_on), .lo_on(lo_on), .floating(floating));

  // ----------------------------------------------------------------
  // Clock, sync source, watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    sc <= (sc == 11) ? 0 : sc + 1;
    sync_clock_in <= sync_run ? (sc < 6) : sync_lvl;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic measure(output int pp, output int hh);
    int n;
    logic pv;
    n = 0;
    pv = 1'b0;
    pp = 0;
    hh = 0;
    while (hi_on[0] === 1'b1 && n < 300) begin
      @(posedge clk); #1; n++;
    end
    while (hi_on[0] !== 1'b1 && n < 300) begin
      @(posedge clk); #1; n++;
    end
    while ((pp == 0 || !(hi_on[0] === 1'b1 && !pv)) && n < 600) begin
      pv = hi_on[0];
      hh += pv;
      @(posedge clk); #1; n++;
      pp++;
    end
  endtask
  task automatic count(input int n, output int hh, output int ll, output int ff, output int rr);
    logic pv;
    hh = 0;
    ll = 0;
    ff = 0;
    rr = 0;
    repeat (n) begin
      pv = chain_clock_out;
      @(posedge clk); #1;
      hh += hi_on[0];
      ll += lo_on[0];
      ff += floating[0];
      rr += (chain_clock_out && !pv);
    end
  endtask
  task automatic wait_ssr(input logic v, input int lim);
    int n;
    n = 0;
    while (soft_start_reset[0] !== v && n < lim) begin
      @(posedge clk); #1; n++;
    end
    check(soft_start_reset[0], v);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    rstn <= 1'b1;
    tick(20); #1;
    check(channel_drive_oe_n, 4'hF);
    check({reference_on, oscillator_on, chain_clock_out}, 3'h1);
    tick(1);
    channel_enable <= 4'h1;
    tick(10); #1;
    check({reference_on, duty_hold, channel_drive_oe_n[3:1]}, 8'hF7);
    measure(p, h);
    check(p, 17);
    check(h, 15);
    count(170, h, l, f, r);
    check(r, 10);
    tick(1);
    frequency_select <= 1'b1;
    tick(10);
    measure(p, h);
    check(p, 10);
    check(h, 9);
    tick(1);
    error_above_floor[0] <= 1'b0;
    tick(20);
    count(30, h, l, f, r);
    check(h, 0);
    check(l, 30);
    tick(1);
    error_above_floor[0] <= 1'b1;
    ramp_crossed[0] <= 1'b1;
    tick(20);
    measure(p, h);
    check(p, 10);
    check(h, 1);
    tick(1);
    ramp_crossed[0] <= 1'b0;
    error_above_floor[0] <= 1'b0;
    negative_overcurrent[0] <= 1'b1;
    tick(20);
    count(160, h, l, f, r);
    check(h, 0);
    check(l, 2);
    check(f, 158);
    tick(1);
    negative_overcurrent[0] <= 1'b0;
    error_above_floor[0] <= 1'b1;
    overcurrent_fault[0] <= 1'b1;
    tick(1250); #1;
    check(soft_start_reset[0], 1'b0);
    wait_ssr(1'b1, 100);
    tick(2); #1;
    check(channel_drive_oe_n[0], 1'b1);
    tick(1);
    overcurrent_fault[0] <= 1'b0;
    tick(40); #1;
    check(soft_start_reset[0], 1'b1);
    wait_ssr(1'b0, 100);
    tick(1);
    overcurrent_fault[0] <= 1'b1;
    tick(1000);
    overcurrent_fault[0] <= 1'b0;
    tick(80);
    overcurrent_fault[0] <= 1'b1;
    tick(1000); #1;
    check(soft_start_reset[0], 1'b0);
    tick(1);
    overcurrent_fault[0] <= 1'b0;
    tick(60);
    overcurrent_fault[0] <= 1'b1;
    wait_ssr(1'b1, 400);
    tick(1);
    overcurrent_fault[0] <= 1'b0;
    wait_ssr(1'b0, 200);
    tick(1);
    sync_run <= 1'b1;
    tick(80); #1;
    check(sync_locked, 1'b1);
    measure(p, h);
    check(p, 12);
    check(h, 11);
    tick(1);
    sync_run <= 1'b0;
    sync_lvl <= 1'b1;
    tick(100); #1;
    check(sync_locked, 1'b0);
    measure(p, h);
    check(p, 14);
    check(h, 12);
    tick(1);
    supply_lockout <= 1'b1;
    tick(5); #1;
    check({channel_drive_oe_n, duty_hold}, 8'hFF);
    tick(1);
    supply_lockout <= 1'b0;
    shared_duty <= 1'b1;
    tick(30); #1;
    check({channel_drive_oe_n[0], duty_hold}, 5'h0F);
    tick(1);
    channel_enable <= 4'hF;
    tick(30); #1;
    check({channel_drive_oe_n, duty_hold}, 8'h00);
    tick(1);
    channel_enable <= 4'h0;
    tick(6); #1;
    check({reference_on, oscillator_on, chain_clock_out}, 3'h1);
    tally_and_finish();
  end
endmodule // tb
bind sdpwm_top sdpwm_monitor #(.RESTART_CYCLES(RESTART_CYCLES)) sdpwm_monitor_inst (
  .clk                  (clk),
  .rstn                 (rstn),
  .channel_enable       (channel_enable),
  .shared_duty          (shared_duty),
  .supply_lockout       (supply_lockout),
  .ramp_crossed         (ramp_crossed),
  .negative_overcurrent (negative_overcurrent),
  .channel_drive        (channel_drive),
  .channel_drive_oe_n   (channel_drive_oe_n),
  .duty_hold            (duty_hold),
  .reference_on         (reference_on),
  .oscillator_on        (oscillator_on),
  .chain_clock_out      (chain_clock_out)
);
`default_nettype wire
